// [pkg/hirq_pkg.sv]
// Shared constants and types for the host interrupt mask and identity block
package hirq_pkg;

  localparam int ADDR_W = 8;

  localparam logic [7:0] IDX_HOST_CTRL = 8'h01;
  localparam logic [7:0] IDX_HW_SETUP = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h24;
  localparam logic [7:0] IDX_MASK = 8'h25;
  localparam logic [7:0] IDX_IDENTITY = 8'h27;
  localparam logic [7:0] IDX_CLEAR = 8'h30;

  localparam logic [7:0] ADDR_HOST_CTRL = {IDX_HOST_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_HW_SETUP = {IDX_HW_SETUP[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] ADDR_MASK = {IDX_MASK[5:0], 2'b00};
  localparam logic [7:0] ADDR_IDENTITY = {IDX_IDENTITY[5:0], 2'b00};
  localparam logic [7:0] ADDR_CLEAR = {IDX_CLEAR[5:0], 2'b00};

  localparam int BIT_SOF = 0;
  localparam int BIT_ASYNC = 1;
  localparam int BIT_XFER = 2;
  localparam int BIT_OPUPD = 4;
  localparam int BIT_SUSP = 5;
  localparam int BIT_CLK = 6;
  localparam logic [15:0] EVT_VALID = 16'h0077;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam int HW_GLOBAL_EN_BIT = 0;
  localparam int CTRL_SUSPEND_BIT = 0;

  // Arbitrary neutral identity values
  localparam logic [7:0] ID_PRODUCT = 8'h5a;
  localparam logic [6:0] ID_REVISION = 7'h08;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TYP_US = 160;
  localparam int SETTLE_MAX_MS = 1;
  localparam int SETTLE_TYP_CYC = (SETTLE_TYP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_MAX_CYC = (SETTLE_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 14;

  typedef enum logic [2:0] {
    SUSP_RUN = 3'b001,
    SUSP_WAIT = 3'b010,
    SUSP_HALT = 3'b100
  } hirq_susp_e;

endpackage

// [pkg/hirq_evt_if.sv]
// Event and clear vectors between the register front end and the status bank
`timescale 1ns/1ps
`default_nettype none
interface hirq_evt_if;
  logic [15:0] evt;
  logic [15:0] clr;
  logic [15:0] status;
  modport src (output evt, output clr, input status);
  modport bank (input evt, input clr, output status);
endinterface
`default_nettype wire

// [core/hirq_settle_timer.sv]
// Clock settle timer started by a wake-up
`timescale 1ns/1ps
`default_nettype none
module hirq_settle_timer #(
  parameter int MAX_CYC = hirq_pkg::SETTLE_MAX_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  input wire logic clock_locked,
  // Result
  output logic ready_pulse,
  output logic busy
);
  import hirq_pkg::*;

  localparam logic [SETTLE_CNT_W-1:0] TYP_CNT = SETTLE_CNT_W'(SETTLE_TYP_CYC);
  localparam logic [SETTLE_CNT_W-1:0] MAX_CNT = SETTLE_CNT_W'(MAX_CYC - 1);

  logic busy_q;
  logic ready_q;
  logic done;
  logic [SETTLE_CNT_W-1:0] cnt_q;

  // Locked clock is trusted only after the typical settle time; the limit forces it
  assign done = busy_q && ((clock_locked && cnt_q >= TYP_CNT) || cnt_q >= MAX_CNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (done) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      cnt_q <= '0;
    end else if (busy_q && cnt_q != MAX_CNT) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= done && !start;
    end
  end

  assign ready_pulse = ready_q;
  assign busy = busy_q;
endmodule
`default_nettype wire

// [core/hirq_event_bank.sv]
// Sticky interrupt status bits and masked request output
`timescale 1ns/1ps
`default_nettype none
module hirq_event_bank (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events in, status out
  hirq_evt_if.bank ev,
  // Gating
  input wire logic [15:0] mask,
  input wire logic global_en,
  // Request
  output logic irq
);
  import hirq_pkg::*;

  logic [15:0] st_q;
  logic irq_q;

  for (genvar i = 0; i < 16; i++) begin : g_bit
    // A new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        st_q[i] <= 1'b0;
      end else begin
        st_q[i] <= EVT_VALID[i] & (ev.evt[i] | (st_q[i] & ~ev.clr[i]));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= global_en & |(st_q & mask & EVT_VALID);
    end
  end

  assign ev.status = st_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// [core/hirq_top.sv]
// Interrupt mask, identity and suspend control behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module hirq_top #(
  parameter int SETTLE_MAX_CYC = hirq_pkg::SETTLE_MAX_CYC,
  parameter logic IMPROVED_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [hirq_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [hirq_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // Read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Controller events
  input wire logic op_update_event,
  input wire logic xfer_done_internal,
  input wire logic xfer_done_external,
  input wire logic async_list_event,
  input wire logic frame_start_event,
  // Suspend and wake
  input wire logic downstream_suspended,
  input wire logic wake_request,
  input wire logic clock_locked,
  output logic sof_enable,
  output logic suspended,
  // Interrupt request
  output logic irq
);
  import hirq_pkg::*;

  hirq_evt_if ev ();

  // Write channel holding
  logic aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [15:0] w_data_q;
  logic [1:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;

  // Read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  logic rd_fire;

  // Registers
  logic [15:0] mask_q;
  logic global_en_q;
  logic suspend_req_q;
  logic [15:0] identity;

  // Suspend sequencing
  hirq_susp_e susp_q;
  hirq_susp_e susp_d;
  logic susp_evt;
  logic wake_start;
  logic clk_ready_evt;
  logic settle_busy;

  // Decoded write strobes
  logic wr_mask;
  logic wr_hw;
  logic wr_ctrl;
  logic wr_clear;
  logic [15:0] wr_bytes;

  function automatic logic [15:0] merge16(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] strb
  );
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // Write address and data are taken independently, in either order
  assign awready = !aw_held_q;
  assign wready = !w_held_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= wdata[15:0];
      w_strb_q <= wstrb[1:0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  assign wr_mask = wr_fire && aw_addr_q == ADDR_MASK;
  assign wr_hw = wr_fire && aw_addr_q == ADDR_HW_SETUP;
  assign wr_ctrl = wr_fire && aw_addr_q == ADDR_HOST_CTRL;
  assign wr_clear = wr_fire && aw_addr_q == ADDR_CLEAR;
  assign wr_bytes = merge16(16'h0000, w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      case (aw_addr_q)
        ADDR_MASK, ADDR_HW_SETUP, ADDR_HOST_CTRL, ADDR_CLEAR: begin
          bresp_q <= RESP_OKAY;
        end
        // Read-only words refuse writes
        ADDR_IDENTITY, ADDR_STATUS: begin
          bresp_q <= RESP_SLVERR;
        end
        default: begin
          bresp_q <= RESP_DECERR;
        end
      endcase
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Mask starts all zero so nothing can request until software enables it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= merge16(mask_q, w_data_q, w_strb_q) & EVT_VALID;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_en_q <= 1'b0;
    end else if (wr_hw && w_strb_q[0]) begin
      global_en_q <= w_data_q[HW_GLOBAL_EN_BIT];
    end
  end

  // Software write wins over a wake clearing the request in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suspend_req_q <= 1'b0;
    end else if (wr_ctrl && w_strb_q[0]) begin
      suspend_req_q <= w_data_q[CTRL_SUSPEND_BIT];
    end else if (susp_q == SUSP_HALT && wake_request) begin
      suspend_req_q <= 1'b0;
    end
  end

  // Suspend only lands once every downstream device has gone quiet
  always_comb begin
    susp_d = susp_q;
    case (susp_q)
      SUSP_RUN: begin
        if (suspend_req_q) begin
          susp_d = SUSP_WAIT;
        end
      end
      SUSP_WAIT: begin
        if (!suspend_req_q) begin
          susp_d = SUSP_RUN;
        end else if (downstream_suspended) begin
          susp_d = SUSP_HALT;
        end
      end
      SUSP_HALT: begin
        if (wake_request || !suspend_req_q) begin
          susp_d = SUSP_RUN;
        end
      end
      default: begin
        susp_d = SUSP_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_q <= SUSP_RUN;
    end else begin
      susp_q <= susp_d;
    end
  end

  assign susp_evt = susp_q == SUSP_WAIT && susp_d == SUSP_HALT;
  assign wake_start = susp_q == SUSP_HALT && susp_d == SUSP_RUN;
  assign sof_enable = susp_q == SUSP_RUN;
  assign suspended = susp_q == SUSP_HALT;

  hirq_settle_timer #(
    .MAX_CYC(SETTLE_MAX_CYC)
  ) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wake_start),
    .clock_locked(clock_locked),
    .ready_pulse(clk_ready_evt),
    .busy(settle_busy)
  );

  always_comb begin
    ev.evt = 16'h0000;
    ev.evt[BIT_CLK] = clk_ready_evt;
    ev.evt[BIT_SUSP] = susp_evt;
    ev.evt[BIT_OPUPD] = op_update_event;
    ev.evt[BIT_XFER] = xfer_done_internal | xfer_done_external;
    ev.evt[BIT_ASYNC] = async_list_event;
    ev.evt[BIT_SOF] = frame_start_event;
  end

  // Clear is a one-cycle pulse; unstrobed lanes clear nothing
  assign ev.clr = wr_clear ? wr_bytes : 16'h0000;

  hirq_event_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev),
    .mask(mask_q),
    .global_en(global_en_q),
    .irq(irq)
  );

  assign identity = {ID_PRODUCT, ID_REVISION, IMPROVED_VARIANT};

  // Read path: one word at a time, data held until rready
  assign arready = !rvalid_q;
  assign rd_fire = arvalid && !rvalid_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    case (araddr)
      ADDR_MASK: begin
        rd_word = {16'h0000, mask_q};
      end
      ADDR_IDENTITY: begin
        rd_word = {16'h0000, identity};
      end
      ADDR_STATUS: begin
        rd_word = {16'h0000, ev.status};
      end
      ADDR_HW_SETUP: begin
        rd_word = {31'h0000_0000, global_en_q};
      end
      ADDR_HOST_CTRL: begin
        rd_word = {28'h000_0000, settle_busy, suspended, sof_enable, suspend_req_q};
      end
      ADDR_CLEAR: begin
        rd_word = 32'h0000_0000;
      end
      default: begin
        rd_resp = RESP_DECERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_resp;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

endmodule
`default_nettype wire

// [tb/hirq_top_assertions.sv]
// Port-level checks for the interrupt mask and identity block
`timescale 1ns/1ps
`default_nettype none
module hirq_top_assertions
  import hirq_pkg::*;
#(
  parameter int SETTLE_MAX_CYC = 10000,
  parameter logic IMPROVED_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Read side
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Suspend and request
  input wire logic downstream_suspended,
  input wire logic sof_enable,
  input wire logic suspended,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken(a);
    arvalid && arready && araddr == a;
  endsequence
  reset_quiet_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && sof_enable) else $error("outputs busy after reset");
  irq_reset_a: assert property ($rose(aresetn) |-> !irq [*4]) else $error("request raised before any enable");
  write_answer_a: assert property (wr_taken |-> ##[1:2] bvalid) else $error("write response missing");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  id_value_a: assert property (rd_taken(ADDR_IDENTITY) |=> rresp == RESP_OKAY &&
    rdata == {16'h0000, ID_PRODUCT, ID_REVISION, IMPROVED_VARIANT}) else $error("identity value wrong");
  id_readonly_a: assert property (wr_taken and awaddr == ADDR_IDENTITY |-> ##[1:2] (bvalid && bresp == RESP_SLVERR))
    else $error("identity write accepted");
  mask_reserved_a: assert property (rd_taken(ADDR_MASK) |=> rdata[15:7] == 9'h000 && !rdata[3])
    else $error("reserved mask bit set");
  halt_cause_a: assert property ($rose(suspended) |-> $past(downstream_suspended) && !sof_enable)
    else $error("halt without downstream suspend");
  run_excl_a: assert property (!(sof_enable && suspended)) else $error("frame starts while halted");
endmodule
bind hirq_top hirq_top_assertions #(.SETTLE_MAX_CYC(SETTLE_MAX_CYC), .IMPROVED_VARIANT(IMPROVED_VARIANT)) u_chk (
  .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .bvalid, .bready, .bresp,
  .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .downstream_suspended,
  .sof_enable, .suspended, .irq);
`default_nettype wire

// [tb/hirq_host_model.sv]
// Host processor model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module hirq_host_model (
  // Clock
  input wire logic aclk,
  // Write side
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read side
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
  end
  // Each channel held until its own ready; no cycle count assumed
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No timeout of its own: the wait ends on bvalid, or at the bench timeout
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the interrupt mask and identity block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hirq_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] ev;
  logic dsusp, wake, locked, sof_enable, suspended, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Short settle window keeps the run brief but still above the lock threshold
  hirq_top #(.SETTLE_MAX_CYC(2000), .IMPROVED_VARIANT(1'b0)) u_dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .op_update_event(ev[4]), .xfer_done_internal(ev[2]), .xfer_done_external(ev[3]), .async_list_event(ev[1]),
    .frame_start_event(ev[0]), .downstream_suspended(dsusp), .wake_request(wake), .clock_locked(locked),
    .sof_enable, .suspended, .irq);
  hirq_host_model u_host (
    .aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic pulse(int k);
    @(posedge aclk);
    ev <= 5'b00001 << k;
    @(posedge aclk);
    ev <= 5'b00000;
  endtask
  task automatic t_regs();
    logic [15:0] d;
    logic [1:0] r;
    u_host.rd(ADDR_MASK, d, r);
    chk("mask reset", 16'h0000, d);
    u_host.rd(ADDR_IDENTITY, d, r);
    chk("identity", {ID_PRODUCT, ID_REVISION, 1'b0}, d);
    u_host.wr(ADDR_IDENTITY, 16'h0000, r);
    chk("identity write resp", RESP_SLVERR, r);
    u_host.rd(ADDR_IDENTITY, d, r);
    chk("identity kept", {ID_PRODUCT, ID_REVISION, 1'b0}, d);
    u_host.wr(ADDR_MASK, 16'hffff, r);
    chk("mask write resp", RESP_OKAY, r);
    u_host.rd(ADDR_MASK, d, r);
    chk("mask readback", 16'h0077, d);
    u_host.rd(8'hfc, d, r);
    chk("unmapped resp", RESP_DECERR, r);
    // Pending unmasked event, but global enable still off
    pulse(0);
    repeat (2) @(posedge aclk);
    chk("irq without global enable", 1'b0, irq);
    $display("test regs done");
  endtask
  task automatic t_events();
    logic [15:0] d;
    logic [1:0] r;
    int b;
    u_host.wr(ADDR_HW_SETUP, 16'h0001, r);
    for (int k = 0; k < 5; k++) begin
      b = (k == 3) ? 2 : k;
      u_host.wr(ADDR_MASK, 16'h0077 & ~(16'h0001 << b), r);
      pulse(k);
      u_host.rd(ADDR_STATUS, d, r);
      chk("status bit", 16'h0001 << b, d);
      chk("irq masked", 1'b0, irq);
      u_host.wr(ADDR_MASK, 16'h0001 << b, r);
      repeat (2) @(posedge aclk);
      chk("irq enabled", 1'b1, irq);
      u_host.wr(ADDR_HW_SETUP, 16'h0000, r);
      repeat (2) @(posedge aclk);
      chk("irq global off", 1'b0, irq);
      u_host.wr(ADDR_HW_SETUP, 16'h0001, r);
      u_host.wr(ADDR_CLEAR, 16'h00ff, r);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 1'b0, irq);
    end
    $display("test events done");
  endtask
  task automatic t_suspend();
    logic [1:0] r;
    int n;
    u_host.wr(ADDR_MASK, 16'h0020, r);
    u_host.wr(ADDR_HOST_CTRL, 16'h0001, r);
    // State moves on the edge the response is seen; look one edge later
    @(posedge aclk);
    chk("frame starts stop", 1'b0, sof_enable);
    chk("halt before downstream", 1'b0, suspended);
    dsusp <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("halted", 1'b1, suspended);
    chk("irq suspend", 1'b1, irq);
    u_host.wr(ADDR_CLEAR, 16'h00ff, r);
    u_host.wr(ADDR_MASK, 16'h0040, r);
    locked <= 1'b1;
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    dsusp <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 2100) begin
      @(posedge aclk);
      n++;
    end
    chk("frame starts resume", 1'b1, sof_enable);
    chk("irq clock ready", 1'b1, irq);
    chk("settle in window", 1'b1, (n >= 1595) && (n <= 2005));
    $display("test suspend done");
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    aresetn = 1'b0;
    ev = 5'b00000;
    dsusp = 1'b0;
    wake = 1'b0;
    locked = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_events();
    t_suspend();
    end_of_test();
  end
endmodule
`default_nettype wire
